// ### logic/fault_signal_monitor.sv
// Fault signal monitor: pin watch, limits, fail flag and drive gating
`timescale 1ns/1ps
module fault_signal_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic fault_signal_pin,
  input wire fault_monitor_pkg::config_write_t config_write,
  input wire fault_monitor_pkg::limit_write_t limit_write,
  input wire logic fail_clear,
  input wire fault_monitor_pkg::device_state_t device_state,
  input wire logic enable_drive_request,
  input wire logic drive_block,
  output logic low_pulse_mode,
  output logic monitor_disable,
  output logic [fault_monitor_pkg::LIMIT_WIDTH-1:0] low_limit_value,
  output logic [fault_monitor_pkg::LIMIT_WIDTH-1:0] high_limit_value,
  output logic [fault_monitor_pkg::LIMIT_WIDTH-1:0] low_count,
  output logic [fault_monitor_pkg::LIMIT_WIDTH-1:0] high_count,
  output fault_monitor_pkg::monitor_status_t status,
  output logic safe_request,
  output logic enable_drive_output
);

  // Pin synchroniser and edge history
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  logic rise_edge;
  logic fall_edge;

  // Configuration and limits
  logic low_pulse_mode_q;
  logic monitor_disable_q;
  logic monitor_disable_prev_q;
  logic enable_rise;
  logic monitor_on;
  logic [fault_monitor_pkg::LIMIT_WIDTH-1:0] low_limit_q;
  logic [fault_monitor_pkg::LIMIT_WIDTH-1:0] high_limit_q;

  // Counter control
  logic low_restart;
  logic high_restart;
  logic low_run;
  logic high_run;
  logic low_hit;
  logic high_hit;
  logic [fault_monitor_pkg::PRESCALE_WIDTH-1:0] tick_cycles;

  // Fault path
  logic fault_low;
  logic fault_high;
  logic fault;
  logic fault_q;
  logic fail_q;
  logic fail_d;
  logic cause_low_q;
  logic cause_high_q;
  logic synced_q;
  logic safe_request_q;
  logic enable_drive_q;
  fault_monitor_pkg::device_state_t state_prev_q;
  logic [fault_monitor_pkg::ENTRY_COUNT_WIDTH-1:0] entry_count_q;
  logic in_diagnostic;
  logic in_active;

  // Two-stage synchroniser; only the second stage feeds logic
  // Reset high so a pin idling high gives no false edge
  // Costs two clocks on every edge, far below one tick
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end
    else
    begin
      pin_meta_q <= fault_signal_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  // History stage for edge detection
  // No added delay; an edge shows as the synchronised sample changes
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pin_prev_q <= 1'b1;
    else
      pin_prev_q <= pin_sync_q;
  end

  // Edges from synchronised samples only
  // A pin pulse shorter than a clock may be missed entirely
  assign rise_edge = pin_sync_q && !pin_prev_q;
  assign fall_edge = !pin_sync_q && pin_prev_q;

  // Configuration bits; monitor held off until software clears disable
  // Both bits load together; there is no partial write
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_pulse_mode_q <= fault_monitor_pkg::MODE_RESET;
      monitor_disable_q <= fault_monitor_pkg::DISABLE_RESET;
    end
    else if (config_write.wr)
    begin
      low_pulse_mode_q <= config_write.low_pulse_mode;
      monitor_disable_q <= config_write.monitor_disable;
    end
  end

  // Previous disable value, to see the 1-to-0 enable step
  // Only PWM mode uses this step to restart a counter
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      monitor_disable_prev_q <= fault_monitor_pkg::DISABLE_RESET;
    else
      monitor_disable_prev_q <= monitor_disable_q;
  end

  // Enable step and state decodes
  assign enable_rise = monitor_disable_prev_q && !monitor_disable_q;
  assign monitor_on = !monitor_disable_q;
  assign in_diagnostic = (device_state == fault_monitor_pkg::STATE_DIAGNOSTIC);
  assign in_active = (device_state == fault_monitor_pkg::STATE_ACTIVE);

  // Threshold registers; writes outside diagnostic are dropped silently
  // Refused writes leave no trace at the ports
  // A lowered limit acts on the very next compare
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_limit_q <= fault_monitor_pkg::LIMIT_RESET;
      high_limit_q <= fault_monitor_pkg::LIMIT_RESET;
    end
    else if (in_diagnostic)
    begin
      if (limit_write.wr_low)
        low_limit_q <= limit_write.data;
      if (limit_write.wr_high)
        high_limit_q <= limit_write.data;
    end
  end

  // Tick rate per mode
  // A mode change mid-phase is covered by the write restart
  assign tick_cycles = low_pulse_mode_q ?
    fault_monitor_pkg::PRESCALE_WIDTH'(fault_monitor_pkg::LOW_PULSE_TICK_CYCLES) :
    fault_monitor_pkg::PRESCALE_WIDTH'(fault_monitor_pkg::PWM_TICK_CYCLES);

  // Low counter restart: falling edge in either mode, enable-while-low
  // in PWM mode, any fault, any config write, or monitor off
  // Priority: off and writes first, then faults, then edges
  always_comb
  begin
    low_restart = 1'b0;
    if (!monitor_on || config_write.wr)
      low_restart = 1'b1;
    else if (fault)
      low_restart = 1'b1;
    else if (low_pulse_mode_q)
      low_restart = fall_edge;
    else
      low_restart = fall_edge || (enable_rise && !pin_sync_q);
  end

  // High counter restart: rising edge or enable-while-high, PWM only
  // In low-pulse mode the high counter is simply parked at zero
  always_comb
  begin
    high_restart = 1'b0;
    if (!monitor_on || config_write.wr || low_pulse_mode_q)
      high_restart = 1'b1;
    else if (fault)
      high_restart = 1'b1;
    else
      high_restart = rise_edge || (enable_rise && pin_sync_q);
  end

  // Counting windows; a rising edge ends the low window
  // A held low count survives until the next falling edge, fault or config write
  assign low_run = monitor_on && !pin_sync_q;
  assign high_run = monitor_on && !low_pulse_mode_q && pin_sync_q;

  // Low phase duration, both modes
  // Shares its tick rate with the high counter
  duration_counter #(
    .COUNT_WIDTH(fault_monitor_pkg::LIMIT_WIDTH),
    .PRESCALE_WIDTH(fault_monitor_pkg::PRESCALE_WIDTH)
  ) low_counter (
    .clock(clock),
    .rst_n(rst_n),
    .restart(low_restart),
    .run(low_run),
    .tick_cycles(tick_cycles),
    .limit(low_limit_q),
    .count(low_count),
    .hit(low_hit)
  );

  // High phase duration, PWM mode only
  // Held in restart throughout low-pulse mode
  duration_counter #(
    .COUNT_WIDTH(fault_monitor_pkg::LIMIT_WIDTH),
    .PRESCALE_WIDTH(fault_monitor_pkg::PRESCALE_WIDTH)
  ) high_counter (
    .clock(clock),
    .rst_n(rst_n),
    .restart(high_restart),
    .run(high_run),
    .tick_cycles(tick_cycles),
    .limit(high_limit_q),
    .count(high_count),
    .hit(high_hit)
  );

  // Fault detection; compare is >= so a lowered limit trips at once
  // A zero limit behaves as one, since a zero count never trips
  assign fault_low = monitor_on && low_hit;
  assign fault_high = monitor_on && !low_pulse_mode_q && high_hit;
  assign fault = fault_low || fault_high;

  // Fault pulse delayed by one clock toward safe entry
  // Registered so safe entry lags the flag by exactly one clock
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      fault_q <= 1'b0;
    else
      fault_q <= fault;
  end

  // Sticky fail flag; a new fault beats a clear in the same cycle
  // Losing a fault to a clear would hide it from software
  always_comb
  begin
    fail_d = fail_q;
    if (fail_clear)
      fail_d = 1'b0;
    if (fault)
      fail_d = 1'b1;
  end

  // Fail flag register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      fail_q <= 1'b0;
    else
      fail_q <= fail_d;
  end

  // Cause bits follow the fail flag's set and clear
  // Each cause keeps its own set-over-clear priority
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cause_low_q <= 1'b0;
      cause_high_q <= 1'b0;
    end
    else
    begin
      if (fault_low)
        cause_low_q <= 1'b1;
      else if (fail_clear)
        cause_low_q <= 1'b0;
      if (fault_high)
        cause_high_q <= 1'b1;
      else if (fail_clear)
        cause_high_q <= 1'b0;
    end
  end

  // Sync indicator: first pin edge seen since monitoring began
  // Only reported; the counters resync on their own edges
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      synced_q <= 1'b0;
    else if (!monitor_on)
      synced_q <= 1'b0;
    else if (rise_edge || fall_edge)
      synced_q <= 1'b1;
  end

  // Safe request one clock after the flag; never from diagnostic
  // A single-clock pulse; the state machine must latch it
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      safe_request_q <= 1'b0;
    else
      safe_request_q <= fault_q && in_active;
  end

  // Observed state, for counting active-to-safe steps
  // Follows whatever the state machine reports, one clock late
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_prev_q <= fault_monitor_pkg::STATE_DIAGNOSTIC;
    else
      state_prev_q <= device_state;
  end

  // Safe entry counter wraps at its width, as a plain modular count
  // Sixteen entries read back as zero; software must track wraps
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      entry_count_q <= fault_monitor_pkg::ENTRY_COUNT_RESET;
    else if ((state_prev_q == fault_monitor_pkg::STATE_ACTIVE) &&
             (device_state == fault_monitor_pkg::STATE_SAFE))
      entry_count_q <= entry_count_q + 1'b1;
  end

  // Drive output held low while the flag or another block stands
  // Uses the next flag value so the output drops on the same edge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      enable_drive_q <= 1'b0;
    else
      enable_drive_q <= enable_drive_request && !fail_d && !drive_block;
  end

  // Readback and outputs
  // Every output below is a register or a direct register copy
  assign low_pulse_mode = low_pulse_mode_q;
  assign monitor_disable = monitor_disable_q;
  assign low_limit_value = low_limit_q;
  assign high_limit_value = high_limit_q;
  assign status.fail_flag = fail_q;
  assign status.cause_low = cause_low_q;
  assign status.cause_high = cause_high_q;
  assign status.synced = synced_q;
  assign status.safe_entry_counter = entry_count_q;
  assign safe_request = safe_request_q;
  assign enable_drive_output = enable_drive_q;

endmodule // fault_signal_monitor

// ### logic/fault_monitor_pkg.sv
// Constants, types and field layouts shared by the fault signal monitor
package fault_monitor_pkg;

  // System clock and tick periods
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int LOW_PULSE_TICK_NS = 5000;
  localparam int PWM_TICK_NS = 15000;
  localparam int LOW_PULSE_TICK_CYCLES = LOW_PULSE_TICK_NS / CLOCK_PERIOD_NS;
  localparam int PWM_TICK_CYCLES = PWM_TICK_NS / CLOCK_PERIOD_NS;
  localparam int PRESCALE_WIDTH = 11;

  // Field widths
  localparam int LIMIT_WIDTH = 8;
  localparam int ENTRY_COUNT_WIDTH = 4;

  // Reset values
  localparam logic [LIMIT_WIDTH-1:0] LIMIT_RESET = 8'hff;
  localparam logic MODE_RESET = 1'b0;
  localparam logic DISABLE_RESET = 1'b1;
  localparam logic [ENTRY_COUNT_WIDTH-1:0] ENTRY_COUNT_RESET = 4'h0;

  // Device state reported by the surrounding state machine
  typedef enum logic [1:0] {
    STATE_DIAGNOSTIC = 2'b00,
    STATE_ACTIVE = 2'b01,
    STATE_SAFE = 2'b11,
    STATE_OTHER = 2'b10
  } device_state_t;

  // Configuration write: mode select and monitor disable
  typedef struct packed {
    logic wr;
    logic low_pulse_mode;
    logic monitor_disable;
  } config_write_t;

  // Threshold write strobes with shared data
  typedef struct packed {
    logic wr_low;
    logic wr_high;
    logic [LIMIT_WIDTH-1:0] data;
  } limit_write_t;

  // Status readback
  typedef struct packed {
    logic fail_flag;
    logic cause_low;
    logic cause_high;
    logic synced;
    logic [ENTRY_COUNT_WIDTH-1:0] safe_entry_counter;
  } monitor_status_t;

endpackage

// ### logic/duration_counter.sv
// Prescaled pulse-duration counter with limit compare
`timescale 1ns/1ps
module duration_counter #(
  parameter int COUNT_WIDTH = 8,
  parameter int PRESCALE_WIDTH = 11
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic run,
  input wire logic [PRESCALE_WIDTH-1:0] tick_cycles,
  input wire logic [COUNT_WIDTH-1:0] limit,
  output logic [COUNT_WIDTH-1:0] count,
  output logic hit
);

  logic [PRESCALE_WIDTH-1:0] prescale_q;
  logic tick;

  // Tick only while running; restart holds off counting for as long as it stands
  assign tick = run && !restart && (prescale_q == tick_cycles - 1'b1);

  // Prescaler realigned to every restart
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      prescale_q <= '0;
    else if (restart || !run || tick)
      prescale_q <= '0;
    else
      prescale_q <= prescale_q + 1'b1;
  end

  // Duration count, saturating at all ones so it never wraps to zero
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (restart)
      count <= '0;
    else if (tick && (count != '1))
      count <= count + 1'b1;
  end

  // Reaching the limit, or a limit lowered under a running count
  assign hit = (count != '0) && (count >= limit);

endmodule // duration_counter

// ### tb/fault_monitor_assertions.sv
// Port-level checks on the fault signal monitor
`timescale 1ns/1ps
module fault_monitor_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire fault_monitor_pkg::config_write_t config_write,
  input wire fault_monitor_pkg::limit_write_t limit_write,
  input wire logic fail_clear,
  input wire fault_monitor_pkg::device_state_t device_state,
  input wire logic low_pulse_mode,
  input wire logic monitor_disable,
  input wire logic [7:0] low_limit_value,
  input wire logic [7:0] high_limit_value,
  input wire logic [7:0] low_count,
  input wire logic [7:0] high_count,
  input wire fault_monitor_pkg::monitor_status_t status,
  input wire logic safe_request,
  input wire logic enable_drive_output
);
  // One clock domain, all checks idle in reset
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_mode_readback: assert property (config_write.wr |=>
    low_pulse_mode == $past(config_write.low_pulse_mode)
    && monitor_disable == $past(config_write.monitor_disable))
    else $error("mode or disable readback wrong");
  a_limit_kept: assert property (limit_write.wr_low
    && device_state != fault_monitor_pkg::STATE_DIAGNOSTIC |=> $stable(low_limit_value))
    else $error("low limit written outside diagnostic");
  a_limit_taken: assert property (limit_write.wr_high
    && device_state == fault_monitor_pkg::STATE_DIAGNOSTIC
    |=> high_limit_value == $past(limit_write.data))
    else $error("high limit not taken");
  a_fault_clears: assert property ($rose(status.fail_flag)
    |-> low_count == 8'h00 && high_count == 8'h00)
    else $error("counts not cleared on fault");
  a_no_safe_diag: assert property (
    (device_state == fault_monitor_pkg::STATE_DIAGNOSTIC) [*3] |-> !safe_request)
    else $error("safe request in diagnostic");
  a_flag_sticky: assert property ($fell(status.fail_flag) |-> $past(fail_clear))
    else $error("fail flag dropped without clear");
  a_drive_held_low: assert property (status.fail_flag |-> !enable_drive_output)
    else $error("drive output high with fail flag");
  a_safe_after_flag: assert property (safe_request |-> $past(status.fail_flag))
    else $error("safe request without earlier flag");
  a_entry_count: assert property ($past(device_state) == fault_monitor_pkg::STATE_ACTIVE
    && device_state == fault_monitor_pkg::STATE_SAFE
    |=> status.safe_entry_counter == $past(status.safe_entry_counter) + 4'h1)
    else $error("safe entry counter not stepped");
endmodule // fault_monitor_assertions

// ### tb/fault_pin_driver.sv
// Behavioural controller driving the fault pin as a free running waveform
`timescale 1ns/1ps
module fault_pin_driver (
  input wire logic clock,
  input wire logic [15:0] low_cycles,
  input wire logic [15:0] high_cycles,
  output logic fault_signal_pin
);
  int cnt = 0;
  initial fault_signal_pin = 1'b1;
  // Phase compared to live lengths, so a shortened phase ends at once
  always @(negedge clock)
  begin
    cnt = cnt + 1;
    if (cnt >= (fault_signal_pin ? high_cycles : low_cycles))
    begin
      fault_signal_pin <= !fault_signal_pin;
      cnt = 0;
    end
  end
endmodule // fault_pin_driver

// ### tb/tb.sv
// Self-checking bench for the fault signal monitor
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic pin;
  logic [15:0] low_cycles = 16'h0100;
  logic [15:0] high_cycles = 16'h0100;
  fault_monitor_pkg::config_write_t config_write = '0;
  fault_monitor_pkg::limit_write_t limit_write = '0;
  logic fail_clear = 1'b0;
  fault_monitor_pkg::device_state_t device_state = fault_monitor_pkg::STATE_DIAGNOSTIC;
  logic enable_drive_request = 1'b0;
  logic drive_block = 1'b0;
  logic low_pulse_mode;
  logic monitor_disable;
  logic [7:0] low_limit_value;
  logic [7:0] high_limit_value;
  logic [7:0] low_count;
  logic [7:0] high_count;
  fault_monitor_pkg::monitor_status_t status;
  logic safe_request;
  logic enable_drive_output;
  int n_mismatch = 0;
  int n_tests = 0;
  int seed = 85;
  int lo, hi, thr, r, k;
  fault_signal_monitor i_fault_signal_monitor (.clock, .rst_n, .fault_signal_pin(pin),
    .config_write, .limit_write, .fail_clear, .device_state, .enable_drive_request,
    .drive_block, .low_pulse_mode, .monitor_disable, .low_limit_value, .high_limit_value,
    .low_count, .high_count, .status, .safe_request, .enable_drive_output);
  fault_pin_driver i_fault_pin_driver (.clock, .low_cycles, .high_cycles,
    .fault_signal_pin(pin));
  // 100 MHz clock
  always #5 clock = !clock;
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed & 32'h7fffffff;
  endfunction
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Strobes drop a full cycle before the next one may rise
  task automatic cfg(input logic m, input logic d);
    config_write = {1'b1, m, d};
    cyc(1);
    config_write.wr = 1'b0;
    cyc(1);
  endtask
  task automatic wlim(input logic wl, input logic wh, input logic [7:0] v);
    limit_write = {wl, wh, v};
    cyc(1);
    limit_write = '0;
    cyc(1);
  endtask
  task automatic clr();
    fail_clear = 1'b1;
    cyc(1);
    fail_clear = 1'b0;
    cyc(1);
  endtask
  // Watchdog, well past the expected run
  initial
  begin
    #1_000_000;
    n_mismatch++;
    finish_test();
  end
  // Main sequence
  initial
  begin
    cyc(10);
    rst_n = 1'b1;
    cyc(1);
    chk("mode", 16'h0000, low_pulse_mode);
    chk("disable", 16'h0001, monitor_disable);
    chk("status", 16'h0000, status);
    wlim(1'b1, 1'b1, 8'h01);
    chk("low limit", 16'h0001, low_limit_value);
    low_cycles = 16'h07d0;
    cyc(4500);
    chk("idle", 16'h0000, status.fail_flag);
    for (int m = 1; m >= 0; m--)
    begin
      thr = m ? 1000 : 1500;
      for (int t = 0; t < 4; t++)
      begin
        r = (t < 3) ? t : rnd();
        lo = thr + (r[0] ? 400 : -500) + rnd() % 90;
        hi = m ? 700 : thr + (r[1] ? 400 : -500) + rnd() % 90;
        cfg(m[0], 1'b1);
        wlim(1'b1, 1'b1, m ? 8'h02 : 8'h01);
        chk("mode", m[0], low_pulse_mode);
        chk("high limit", m ? 16'h0002 : 16'h0001, high_limit_value);
        low_cycles = 16'(lo);
        high_cycles = 16'(hi);
        cfg(m[0], 1'b0);
        cyc(2 * (lo + hi) + 20);
        chk("fail", lo > thr || (m == 0 && hi > thr), status.fail_flag);
        chk("cause low", lo > thr, status.cause_low);
        chk("cause high", m == 0 && hi > thr, status.cause_high);
        chk("synced", 16'h0001, status.synced);
        cfg(m[0], 1'b1);
        clr();
        chk("cleared", 16'h0000, status.fail_flag);
        chk("causes", 16'h0000, {status.cause_low, status.cause_high});
      end
    end
    device_state = fault_monitor_pkg::STATE_ACTIVE;
    enable_drive_request = 1'b1;
    wlim(1'b1, 1'b0, 8'h05);
    chk("refused", 16'h0001, low_limit_value);
    low_cycles = 16'h0384;
    high_cycles = 16'h02bc;
    cfg(1'b1, 1'b0);
    chk("drive", 16'h0001, enable_drive_output);
    k = 0;
    while (safe_request !== 1'b1 && k < 3000)
    begin
      cyc(1);
      k++;
    end
    chk("safe", 16'h0001, safe_request);
    chk("flag", 16'h0001, status.fail_flag);
    chk("drive", 16'h0000, enable_drive_output);
    device_state = fault_monitor_pkg::STATE_SAFE;
    cyc(3);
    chk("entries", 16'h0001, status.safe_entry_counter);
    device_state = fault_monitor_pkg::STATE_DIAGNOSTIC;
    cfg(1'b1, 1'b1);
    clr();
    chk("drive", 16'h0001, enable_drive_output);
    drive_block = 1'b1;
    cyc(2);
    chk("blocked", 16'h0000, enable_drive_output);
    drive_block = 1'b0;
    // Lowered limit under a running high count
    cfg(1'b0, 1'b1);
    wlim(1'b1, 1'b1, 8'hff);
    low_cycles = 16'h0064;
    high_cycles = 16'hea60;
    cyc(1000);
    cfg(1'b0, 1'b0);
    cyc(3200);
    chk("high count", 16'h0002, high_count);
    wlim(1'b0, 1'b1, 8'h01);
    chk("fail", 16'h0001, status.fail_flag);
    chk("high count", 16'h0000, high_count);
    // Low-pulse count held across a long high phase
    cfg(1'b1, 1'b1);
    clr();
    wlim(1'b1, 1'b1, 8'hff);
    cfg(1'b1, 1'b0);
    low_cycles = 16'h04b0;
    high_cycles = 16'h0064;
    cyc(3);
    high_cycles = 16'hea60;
    cyc(1400);
    chk("low count", 16'h0002, low_count);
    chk("fail", 16'h0000, status.fail_flag);
    finish_test();
  end
endmodule // tb
bind fault_signal_monitor fault_monitor_assertions i_fault_monitor_assertions (.clock, .rst_n,
  .config_write, .limit_write, .fail_clear, .device_state, .low_pulse_mode, .monitor_disable,
  .low_limit_value, .high_limit_value, .low_count, .high_count, .status, .safe_request,
  .enable_drive_output);
